// ===== include/frbp_if.sv
`timescale 1ns/1ps
interface frbp_if;
	logic       sck;
	logic       cs_n;
	logic [3:0] host_dq_o;
	logic [3:0] host_dq_oe;
	logic [3:0] dev_dq_o;
	logic [3:0] dev_dq_oe;
	logic [3:0] dq;

	// ==========================================
	// Line resolution, pulled high when undriven
	// ==========================================
	assign dq = (dev_dq_oe & dev_dq_o) | (host_dq_oe & host_dq_o) | ~(dev_dq_oe | host_dq_oe);

	modport device (input sck, input cs_n, input dq, output dev_dq_o, output dev_dq_oe);
	modport host (output sck, output cs_n, output host_dq_o, output host_dq_oe, input dq);
endinterface

// ===== include/frbp_pkg.sv
package frbp_pkg;

	// ==========================================
	// Link timing
	// ==========================================
	// Core cycles per serial-clock half period (host divider)
	localparam int         HALF_CYC   = 4;
	localparam logic [1:0] HC_LAST    = 2'(HALF_CYC - 1);
	localparam logic [1:0] HC_DRV     = 2'h1;
	// Idle clocks the host gives after reset, select high
	localparam int         WAKE_CLKS  = 2;
	// Dummy clocks of every fast variant
	localparam int         DUMMY_CLKS = 8;
	localparam int         ADDR3_BITS = 24;
	localparam int         ADDR4_BITS = 32;

	// ==========================================
	// Protocols and opcodes
	// ==========================================
	localparam logic [1:0] PROT_EXT  = 2'h0;
	localparam logic [1:0] PROT_DUAL = 2'h1;
	localparam logic [1:0] PROT_QUAD = 2'h2;

	localparam logic [7:0] OP_RD3 = 8'h03;
	localparam logic [7:0] OP_FR3 = 8'h0b;
	localparam logic [7:0] OP_DO3 = 8'h3b;
	localparam logic [7:0] OP_DI3 = 8'hbb;
	localparam logic [7:0] OP_QO3 = 8'h6b;
	localparam logic [7:0] OP_QI3 = 8'heb;
	localparam logic [7:0] OP_RD4 = 8'h13;
	localparam logic [7:0] OP_FR4 = 8'h0c;
	localparam logic [7:0] OP_DO4 = 8'h3c;
	localparam logic [7:0] OP_DI4 = 8'hbc;
	localparam logic [7:0] OP_QO4 = 8'h6c;
	localparam logic [7:0] OP_QI4 = 8'hec;
	localparam logic [7:0] OP_FRD = 8'h0d;
	localparam logic [7:0] OP_DOD = 8'h3d;
	localparam logic [7:0] OP_DID = 8'hbd;
	localparam logic [7:0] OP_QOD = 8'h6d;
	localparam logic [7:0] OP_QID = 8'hed;
	localparam logic [7:0] OP_EN4 = 8'hb7;
	localparam logic [7:0] OP_EX4 = 8'he9;

	// ==========================================
	// Types
	// ==========================================
	typedef enum logic [2:0] {K_READ, K_FAST, K_DOUT, K_DIO, K_QOUT, K_QIO} frbp_kind_e;
	typedef enum {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} frbp_state_e;
	typedef enum {H_WAKE, H_IDLE, H_CMD, H_ADDR, H_DUMMY, H_DATA, H_END} frbp_hstate_e;

	typedef struct packed {
		logic       ok;
		logic       mode_cmd;
		logic       mode_val;
		logic       dtr;
		frbp_kind_e kind;
		logic [2:0] ol;
		logic [2:0] al;
		logic [2:0] dl;
		logic [5:0] aclk;
		logic [3:0] dclk;
	} frbp_dec_s;

	// ==========================================
	// Helpers
	// ==========================================
	// Lines used by opcodes in a protocol
	function automatic logic [2:0] plines(input logic [1:0] prot);
		return (prot == PROT_QUAD) ? 3'h4 : (prot == PROT_DUAL) ? 3'h2 : 3'h1;
	endfunction

	// Transfers needed for one byte on w lines
	function automatic logic [3:0] per_byte(input logic [2:0] w);
		return (w == 3'h4) ? 4'h2 : (w == 3'h2) ? 4'h4 : 4'h8;
	endfunction

	// Line mask; single-line data leaves on line one
	function automatic logic [3:0] mask(input logic [2:0] w, input logic data);
		return (w == 3'h4) ? 4'hf : (w == 3'h2) ? 4'h3 : data ? 4'h2 : 4'h1;
	endfunction

	// Take w bits from the lines, right aligned
	function automatic logic [3:0] pick(input logic [3:0] dq, input logic [2:0] w, input logic data);
		return (w == 3'h4) ? dq : (w == 3'h2) ? {2'h0, dq[1:0]} : {3'h0, data ? dq[1] : dq[0]};
	endfunction

	// Put w right-aligned bits onto their lines
	function automatic logic [3:0] place(input logic [3:0] b, input logic [2:0] w, input logic data);
		return (w == 3'h4) ? b : (w == 3'h2) ? {2'h0, b[1:0]} : data ? {2'h0, b[0], 1'b0} : {3'h0, b[0]};
	endfunction

	// Shift w bits in at the bottom
	function automatic logic [31:0] shift(input logic [31:0] sr, input logic [3:0] b, input logic [2:0] w);
		return (w == 3'h4) ? {sr[27:0], b} : (w == 3'h2) ? {sr[29:0], b[1:0]} : {sr[30:0], b[0]};
	endfunction

	// Chunk idx of a byte on w lines, most significant first
	function automatic logic [3:0] chunk(input logic [7:0] d, input logic [3:0] idx, input logic [2:0] w);
		logic [2:0] amt;
		logic [7:0] s;
		amt = (w == 3'h4) ? {idx[0], 2'h0} : (w == 3'h2) ? {idx[1:0], 1'b0} : idx[2:0];
		s   = d << amt;
		return (w == 3'h4) ? s[7:4] : (w == 3'h2) ? {2'h0, s[7:6]} : {3'h0, s[7]};
	endfunction

	// Full command decode for a protocol and address mode
	function automatic frbp_dec_s decode(input logic [7:0] op, input logic [1:0] prot, input logic addr4);
		frbp_dec_s d;
		logic      known;
		logic      f4;
		logic      sup;
		int        ab;
		d     = '0;
		known = 1'b1;
		d.ol  = plines(prot);
		case (op)
			OP_RD3, OP_RD4:         d.kind = K_READ;
			OP_FR3, OP_FR4, OP_FRD: d.kind = K_FAST;
			OP_DO3, OP_DO4, OP_DOD: d.kind = K_DOUT;
			OP_DI3, OP_DI4, OP_DID: d.kind = K_DIO;
			OP_QO3, OP_QO4, OP_QOD: d.kind = K_QOUT;
			OP_QI3, OP_QI4, OP_QID: d.kind = K_QIO;
			OP_EN4, OP_EX4:         d.mode_cmd = 1'b1;
			default:                known = 1'b0;
		endcase
		f4         = op inside {OP_RD4, OP_FR4, OP_DO4, OP_DI4, OP_QO4, OP_QI4};
		d.dtr      = op inside {OP_FRD, OP_DOD, OP_DID, OP_QOD, OP_QID};
		d.mode_val = (op == OP_EN4);
		if (prot == PROT_DUAL) begin
			sup  = d.kind inside {K_FAST, K_DOUT, K_DIO};
			d.al = d.ol;
			d.dl = d.ol;
		end else if (prot == PROT_QUAD) begin
			sup  = d.kind inside {K_FAST, K_QOUT, K_QIO};
			d.al = d.ol;
			d.dl = d.ol;
		end else begin
			sup  = 1'b1;
			d.al = (d.kind == K_DIO) ? 3'h2 : (d.kind == K_QIO) ? 3'h4 : 3'h1;
			d.dl = (d.kind inside {K_READ, K_FAST}) ? 3'h1 : (d.kind inside {K_DOUT, K_DIO}) ? 3'h2 : 3'h4;
		end
		d.ok   = known & ~d.mode_cmd & sup;
		ab     = (f4 | addr4) ? ADDR4_BITS : ADDR3_BITS;
		d.aclk = 6'(ab / (int'(d.al) * (d.dtr ? 2 : 1)));
		d.dclk = (d.kind == K_READ) ? 4'h0 : 4'(DUMMY_CLKS);
		return d;
	endfunction

endpackage

// ===== logic/frbp_device.sv
`timescale 1ns/1ps
module frbp_device (
	input  wire logic        RST_B,
	frbp_if.device           LINK,
	input  wire logic [1:0]  PROTOCOL,
	input  wire logic        ADDR4_NV,
	output wire logic [31:0] MEM_ADDR,
	input  wire logic [7:0]  MEM_DATA
);

	frbp_pkg::frbp_state_e st_q;
	frbp_pkg::frbp_dec_s   dec_q;
	frbp_pkg::frbp_dec_s   dec_c;
	logic                  frm_rst_n;
	logic [1:0]            prot_m_q;
	logic [1:0]            prot_s_q;
	logic                  nv_m_q;
	logic                  nv_s_q;
	logic [1:0]            vld_q;
	logic                  mode4_q;
	logic                  loaded_q;
	logic [5:0]            cnt_q;
	logic [31:0]           sr_q;
	logic [31:0]           sh_c;
	logic [31:0]           addr_q;
	logic [3:0]            ci_q;
	logic [3:0]            ci_nx_c;
	logic [3:0]            neg_in_q;
	logic [3:0]            p_q;
	logic [3:0]            n_q;
	logic [3:0]            oe_q;
	logic [2:0]            pl_c;
	logic [2:0]            w_c;
	logic [5:0]            oclk_c;
	logic                  opc_done_c;
	logic                  adr_done_c;

	// ==========================================
	// Frame reset and static inputs
	// ==========================================
	// Frame logic held in reset while select is high
	assign frm_rst_n = RST_B & ~LINK.cs_n;

	// Two-stage capture of the configuration pins
	always_ff @(posedge LINK.sck or negedge RST_B) begin
		if (!RST_B) begin
			prot_m_q <= 2'h0;
			prot_s_q <= 2'h0;
			nv_m_q   <= 1'b0;
			nv_s_q   <= 1'b0;
			vld_q    <= 2'h0;
		end else begin
			prot_m_q <= PROTOCOL;
			prot_s_q <= prot_m_q;
			nv_m_q   <= ADDR4_NV;
			nv_s_q   <= nv_m_q;
			vld_q    <= {vld_q[0], 1'b1};
		end
	end

	// ==========================================
	// Command decode
	// ==========================================
	assign pl_c    = frbp_pkg::plines(prot_s_q);
	assign oclk_c  = {2'h0, frbp_pkg::per_byte(pl_c)};
	assign w_c     = (st_q == frbp_pkg::ST_CMD) ? pl_c : dec_q.al;
	assign ci_nx_c = ci_q + (dec_q.dtr ? 4'h2 : 4'h1);

	// Bits on this rise; double-edge address adds the fall bits first
	always_comb begin
		sh_c = sr_q;
		if (st_q == frbp_pkg::ST_ADDR && dec_q.dtr) begin
			sh_c = frbp_pkg::shift(sh_c, frbp_pkg::pick(neg_in_q, w_c, 1'b0), w_c);
		end
		sh_c = frbp_pkg::shift(sh_c, frbp_pkg::pick(LINK.dq, w_c, 1'b0), w_c);
	end

	assign dec_c      = frbp_pkg::decode(sh_c[7:0], prot_s_q, mode4_q);
	assign opc_done_c = (st_q == frbp_pkg::ST_CMD) && (cnt_q == oclk_c - 6'h1) && !LINK.cs_n;
	assign adr_done_c = (cnt_q == dec_q.aclk - 6'h1);

	// Address mode: strap once after reset, then commands
	always_ff @(posedge LINK.sck or negedge RST_B) begin
		if (!RST_B) begin
			mode4_q  <= 1'b0;
			loaded_q <= 1'b0;
		end else if (opc_done_c && dec_c.mode_cmd) begin
			mode4_q  <= dec_c.mode_val;
			loaded_q <= 1'b1;
		end else if (!loaded_q && vld_q[1]) begin
			mode4_q  <= nv_s_q;
			loaded_q <= 1'b1;
		end
	end

	// ==========================================
	// Command sequencer on the rising edge
	// ==========================================
	always_ff @(posedge LINK.sck or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			st_q   <= frbp_pkg::ST_CMD;
			cnt_q  <= 6'h0;
			sr_q   <= 32'h0;
			dec_q  <= '0;
			addr_q <= 32'h0;
			ci_q   <= 4'h0;
		end else begin
			unique case (st_q)
				frbp_pkg::ST_CMD: begin
					sr_q  <= sh_c;
					cnt_q <= cnt_q + 6'h1;
					if (opc_done_c) begin
						cnt_q <= 6'h0;
						sr_q  <= 32'h0;
						dec_q <= dec_c;
						st_q  <= dec_c.ok ? frbp_pkg::ST_ADDR : frbp_pkg::ST_IGNORE;
					end
				end
				frbp_pkg::ST_ADDR: begin
					sr_q  <= sh_c;
					cnt_q <= cnt_q + 6'h1;
					if (adr_done_c) begin
						addr_q <= sh_c;
						cnt_q  <= 6'h0;
						ci_q   <= 4'h0;
						st_q   <= (dec_q.dclk == 4'h0) ? frbp_pkg::ST_DATA : frbp_pkg::ST_DUMMY;
					end
				end
				frbp_pkg::ST_DUMMY: begin
					cnt_q <= cnt_q + 6'h1;
					if (cnt_q == {2'h0, dec_q.dclk} - 6'h1) begin
						cnt_q <= 6'h0;
						st_q  <= frbp_pkg::ST_DATA;
					end
				end
				frbp_pkg::ST_DATA: begin
					if (ci_nx_c == frbp_pkg::per_byte(dec_q.dl)) begin
						ci_q   <= 4'h0;
						addr_q <= addr_q + 32'h1;
					end else begin
						ci_q <= ci_nx_c;
					end
				end
				frbp_pkg::ST_IGNORE: begin
					cnt_q <= 6'h0;
				end
			endcase
		end
	end

	// ==========================================
	// Memory address
	// ==========================================
	// Byte address straight from its flop, zero between frames
	assign MEM_ADDR = addr_q;

	// ==========================================
	// Falling-edge capture and output
	// ==========================================
	// Address chunk moved on the falling edge
	always_ff @(negedge LINK.sck or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			neg_in_q <= 4'h0;
		end else if (st_q == frbp_pkg::ST_ADDR) begin
			neg_in_q <= LINK.dq;
		end
	end

	// First chunk of each clock leaves on the fall
	always_ff @(negedge LINK.sck or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			n_q  <= 4'h0;
			oe_q <= 4'h0;
		end else if (st_q == frbp_pkg::ST_DATA) begin
			n_q  <= p_q ^ frbp_pkg::place(frbp_pkg::chunk(MEM_DATA, ci_q, dec_q.dl), dec_q.dl, 1'b1);
			oe_q <= frbp_pkg::mask(dec_q.dl, 1'b1);
		end
	end

	// Second chunk on the rise, double-edge only
	always_ff @(posedge LINK.sck or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			p_q <= 4'h0;
		end else if (st_q == frbp_pkg::ST_DATA && dec_q.dtr) begin
			p_q <= n_q ^ frbp_pkg::place(frbp_pkg::chunk(MEM_DATA, ci_q + 4'h1, dec_q.dl), dec_q.dl, 1'b1);
		end
	end

	// Two-edge output pair, one flop changes per edge
	assign LINK.dev_dq_o  = p_q ^ n_q;
	assign LINK.dev_dq_oe = oe_q;

endmodule // frbp_device

// ===== logic/frbp_host.sv
`timescale 1ns/1ps
module frbp_host (
	input  wire logic        CORE_CLK,
	input  wire logic        RST_B,
	frbp_if.host             LINK,
	input  wire logic        START,
	input  wire logic [7:0]  OPCODE,
	input  wire logic [31:0] ADDRESS,
	input  wire logic        ADDR4,
	input  wire logic [1:0]  PROTOCOL,
	input  wire logic [15:0] LENGTH,
	output logic             BUSY,
	output logic [7:0]       RD_DATA,
	output logic             RD_VALID,
	output logic             DONE
);

	frbp_pkg::frbp_hstate_e st_q;
	frbp_pkg::frbp_dec_s    dec_q;
	frbp_pkg::frbp_dec_s    dec_c;
	logic [1:0]             hc_q;
	logic                   sck_q;
	logic                   cs_n_q;
	logic [3:0]             dq_o_q;
	logic [3:0]             dq_oe_q;
	logic [3:0]             dq_m_q;
	logic [3:0]             dq_s_q;
	logic [5:0]             cnt_q;
	logic [31:0]            tx_q;
	logic [31:0]            adr_q;
	logic [15:0]            len_q;
	logic [7:0]             rx_c;
	logic [3:0]             rxb_q;
	logic                   started_q;
	logic                   tog_c;
	logic                   rise_c;
	logic                   drv_c;
	logic                   samp_c;
	logic [2:0]             w_c;

	// ==========================================
	// Serial clock divider and line sync
	// ==========================================
	assign tog_c  = (hc_q == frbp_pkg::HC_LAST);
	assign rise_c = tog_c & ~sck_q;
	assign drv_c  = (hc_q == frbp_pkg::HC_DRV);
	assign samp_c = (st_q == frbp_pkg::H_DATA) && tog_c && (!sck_q || (dec_q.dtr && started_q));
	assign w_c    = (st_q == frbp_pkg::H_CMD) ? dec_q.ol : dec_q.al;
	assign rx_c   = 8'(frbp_pkg::shift({24'h0, RD_DATA}, frbp_pkg::pick(dq_s_q, dec_q.dl, 1'b1), dec_q.dl));
	assign dec_c  = frbp_pkg::decode(OPCODE, PROTOCOL, ADDR4);

	// Clock runs only while a frame or wake-up is active
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			hc_q  <= 2'h0;
			sck_q <= 1'b0;
		end else if ((st_q == frbp_pkg::H_IDLE || st_q == frbp_pkg::H_END) && !sck_q) begin
			// A high half always runs to full length before the clock stops
			hc_q  <= 2'h0;
			sck_q <= 1'b0;
		end else begin
			hc_q  <= hc_q + 2'h1;
			sck_q <= sck_q ^ tog_c;
		end
	end

	// Device data lines pass two flops
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			dq_m_q <= 4'h0;
			dq_s_q <= 4'h0;
		end else begin
			dq_m_q <= LINK.dq;
			dq_s_q <= dq_m_q;
		end
	end

	// ==========================================
	// Transaction sequencer
	// ==========================================
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q      <= frbp_pkg::H_WAKE;
			dec_q     <= '0;
			cs_n_q    <= 1'b1;
			dq_o_q    <= 4'h0;
			dq_oe_q   <= 4'h0;
			cnt_q     <= 6'h0;
			tx_q      <= 32'h0;
			adr_q     <= 32'h0;
			len_q     <= 16'h0;
			rxb_q     <= 4'h0;
			started_q <= 1'b0;
			BUSY      <= 1'b1;
			RD_DATA   <= 8'h0;
			RD_VALID  <= 1'b0;
			DONE      <= 1'b0;
		end else begin
			RD_VALID <= 1'b0;
			DONE     <= 1'b0;
			unique case (st_q)
				frbp_pkg::H_WAKE: begin
					if (rise_c) begin
						cnt_q <= cnt_q + 6'h1;
					end
					// Leave on the fall after the last pulse, so its high half is full
					if (tog_c && sck_q && cnt_q == 6'(frbp_pkg::WAKE_CLKS)) begin
						st_q <= frbp_pkg::H_IDLE;
						BUSY <= 1'b0;
					end
				end
				frbp_pkg::H_IDLE: begin
					cnt_q <= 6'h0;
					if (START) begin
						dec_q  <= dec_c;
						tx_q   <= {OPCODE, 24'h0};
						adr_q  <= (dec_c.aclk * dec_c.al * (dec_c.dtr ? 3'h2 : 3'h1) == 6'(frbp_pkg::ADDR4_BITS))
							? ADDRESS : {ADDRESS[23:0], 8'h0};
						len_q  <= LENGTH;
						cs_n_q <= 1'b0;
						BUSY   <= 1'b1;
						st_q   <= frbp_pkg::H_CMD;
					end
				end
				frbp_pkg::H_CMD: begin
					if (drv_c && !sck_q) begin
						dq_o_q  <= frbp_pkg::place(4'(tx_q[31:28] >> (3'h4 - w_c)), w_c, 1'b0);
						dq_oe_q <= frbp_pkg::mask(w_c, 1'b0);
						tx_q    <= tx_q << w_c;
					end
					if (rise_c) begin
						cnt_q <= cnt_q + 6'h1;
						if (cnt_q == {2'h0, frbp_pkg::per_byte(w_c)} - 6'h1) begin
							cnt_q <= 6'h0;
							tx_q  <= adr_q;
							st_q  <= dec_q.ok ? frbp_pkg::H_ADDR : frbp_pkg::H_END;
						end
					end
				end
				frbp_pkg::H_ADDR: begin
					if (drv_c && (!sck_q || dec_q.dtr)) begin
						dq_o_q  <= frbp_pkg::place(4'(tx_q[31:28] >> (3'h4 - w_c)), w_c, 1'b0);
						dq_oe_q <= frbp_pkg::mask(w_c, 1'b0);
						tx_q    <= tx_q << w_c;
					end
					if (rise_c) begin
						cnt_q <= cnt_q + 6'h1;
						if (cnt_q == dec_q.aclk - 6'h1) begin
							cnt_q     <= 6'h0;
							rxb_q     <= 4'h0;
							started_q <= 1'b0;
							st_q      <= (dec_q.dclk != 4'h0) ? frbp_pkg::H_DUMMY :
								(len_q == 16'h0) ? frbp_pkg::H_END : frbp_pkg::H_DATA;
						end
					end
				end
				frbp_pkg::H_DUMMY: begin
					dq_oe_q <= 4'h0;
					if (rise_c) begin
						cnt_q <= cnt_q + 6'h1;
						if (cnt_q == {2'h0, dec_q.dclk} - 6'h1) begin
							st_q <= (len_q == 16'h0) ? frbp_pkg::H_END : frbp_pkg::H_DATA;
						end
					end
				end
				frbp_pkg::H_DATA: begin
					dq_oe_q <= 4'h0;
					if (samp_c) begin
						started_q <= 1'b1;
						RD_DATA   <= rx_c;
						rxb_q     <= rxb_q + {1'b0, dec_q.dl};
						if (rxb_q + {1'b0, dec_q.dl} == 4'h8) begin
							rxb_q    <= 4'h0;
							RD_VALID <= 1'b1;
							len_q    <= len_q - 16'h1;
							if (len_q == 16'h1) begin
								st_q <= frbp_pkg::H_END;
							end
						end
					end
				end
				frbp_pkg::H_END: begin
					dq_oe_q <= 4'h0;
					// Select rises only once the serial clock is low again
					if (!sck_q) begin
						cs_n_q <= 1'b1;
						DONE   <= 1'b1;
						BUSY   <= 1'b0;
						st_q   <= frbp_pkg::H_IDLE;
					end
				end
			endcase
		end
	end

	assign LINK.sck        = sck_q;
	assign LINK.cs_n       = cs_n_q;
	assign LINK.host_dq_o  = dq_o_q;
	assign LINK.host_dq_oe = dq_oe_q;

endmodule // frbp_host

// ===== sim/frbp_link_assertions.sv
`timescale 1ns/1ps
module frbp_link_assertions (
	input wire logic       CORE_CLK,
	input wire logic       RST_B,
	input wire logic       sck,
	input wire logic       cs_n,
	input wire logic [3:0] host_dq_o,
	input wire logic [3:0] host_dq_oe,
	input wire logic [3:0] dev_dq_o,
	input wire logic [3:0] dev_dq_oe
);
	logic [5:0] cnt_q;

	// ==========================================
	// Frame clock counter
	// ==========================================
	// Serial clock rises since select fell, saturating
	always_ff @(posedge sck or negedge RST_B or posedge cs_n) begin
		if (!RST_B) begin
			cnt_q <= 6'h00;
		end else if (cs_n) begin
			cnt_q <= 6'h00;
		end else if (cnt_q != 6'h3f) begin
			cnt_q <= cnt_q + 6'h01;
		end
	end

	// ==========================================
	// Sequences
	// ==========================================
	sequence sck_rise_s;
		$rose(sck);
	endsequence

	sequence sck_high_s;
		sck [*4] ##1 !sck;
	endsequence

	sequence host_hold_s;
		$stable(host_dq_o) ##1 $stable(host_dq_o);
	endsequence

	// ==========================================
	// Assertions
	// ==========================================
	a_release_deselect: assert property (@(posedge CORE_CLK) disable iff (!RST_B) cs_n |-> dev_dq_oe == 4'h0)
		else $error("device drives a line while deselected");
	a_no_contention: assert property (@(posedge CORE_CLK) disable iff (!RST_B) (dev_dq_oe & host_dq_oe) == 4'h0)
		else $error("host and device drive one line");
	a_opcode_phase: assert property (@(posedge sck) disable iff (!RST_B)
		!cs_n && cnt_q < 6'h02 |-> host_dq_oe[0] && dev_dq_oe == 4'h0)
		else $error("opcode phase not driven by host on line zero");
	a_late_data_start: assert property (@(posedge sck) disable iff (!RST_B) dev_dq_oe != 4'h0 |-> cnt_q >= 6'h0d)
		else $error("device drives before address and dummy clocks");
	a_frame_min_len: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		$rose(cs_n) |-> $past(cnt_q) >= 6'h02)
		else $error("frame ended before the opcode");
	a_dev_edge_only: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		$changed(dev_dq_o) |-> $changed(sck) || $rose(cs_n))
		else $error("device data changed away from a clock edge");
	a_host_bit_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B) sck_rise_s |-> host_hold_s)
		else $error("host line changed around a rising edge");
	a_sck_high_time: assert property (@(posedge CORE_CLK) disable iff (!RST_B) sck_rise_s |-> sck_high_s)
		else $error("serial clock high time wrong");
endmodule // frbp_link_assertions

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam logic [31:0] BASE = 32'h9a5c_37fe;
	localparam int          NB   = 3;
	logic        core_clk  = 1'b0;
	logic        rst_b     = 1'b0;
	logic        start     = 1'b0;
	logic [7:0]  opcode    = 8'h00;
	logic        addr4     = 1'b0;
	logic [1:0]  prot      = 2'h0;
	logic        addr4_nv  = 1'b0;
	logic        busy;
	logic [7:0]  rd_data;
	logic        rd_valid;
	logic        done;
	logic [31:0] mem_addr;
	logic [7:0]  mem_data;
	logic [3:0]  oe_seen   = 4'h0;
	int          oe_at     = -1;
	int          rises     = 0;
	int          failures  = 0;
	int          tests_run = 0;
	int          al_t[6]   = '{1, 1, 1, 2, 1, 4};
	int          dl_t[6]   = '{1, 1, 2, 2, 4, 4};
	logic [7:0]  op3[6]    = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h6b, 8'heb};
	logic [7:0]  op4[6]    = '{8'h13, 8'h0c, 8'h3c, 8'hbc, 8'h6c, 8'hec};
	logic [7:0]  opd[6]    = '{8'h00, 8'h0d, 8'h3d, 8'hbd, 8'h6d, 8'hed};
	wire         any_oe;

	// ==========================================
	// Ends and checker
	// ==========================================
	frbp_if frbp_if_i ();
	frbp_host frbp_host_i (.CORE_CLK(core_clk), .RST_B(rst_b), .LINK(frbp_if_i.host), .START(start),
		.OPCODE(opcode), .ADDRESS(BASE), .ADDR4(addr4), .PROTOCOL(prot), .LENGTH(16'(NB)), .BUSY(busy),
		.RD_DATA(rd_data), .RD_VALID(rd_valid), .DONE(done));
	frbp_device frbp_device_i (.RST_B(rst_b), .LINK(frbp_if_i.device), .PROTOCOL(prot), .ADDR4_NV(addr4_nv),
		.MEM_ADDR(mem_addr), .MEM_DATA(mem_data));
	frbp_link_assertions frbp_link_assertions_i (.CORE_CLK(core_clk), .RST_B(rst_b), .sck(frbp_if_i.sck),
		.cs_n(frbp_if_i.cs_n), .host_dq_o(frbp_if_i.host_dq_o), .host_dq_oe(frbp_if_i.host_dq_oe),
		.dev_dq_o(frbp_if_i.dev_dq_o), .dev_dq_oe(frbp_if_i.dev_dq_oe));

	// ==========================================
	// Clock, memory and link watch
	// ==========================================
	// Core clock
	always #12.5 core_clk = ~core_clk;

	// Memory contents, every address byte matters
	function automatic logic [7:0] mem(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ {a[27:24], a[31:28]} ^ 8'h3c;
	endfunction
	assign mem_data = mem(mem_addr);
	assign any_oe   = |frbp_if_i.dev_dq_oe;

	// Rising edges inside the frame
	always @(posedge frbp_if_i.sck or posedge frbp_if_i.cs_n) begin
		rises = frbp_if_i.cs_n ? 0 : rises + 1;
	end

	// First device drive: when and on which lines
	always @(posedge any_oe) begin
		oe_at   = rises;
		oe_seen = frbp_if_i.dev_dq_oe;
	end

	// ==========================================
	// Shared tasks
	// ==========================================
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic timeout();
		failures++;
		$display("ERROR %0t: host did not respond", $time);
		finish_test();
	endtask

	task automatic reset_to(input logic [1:0] p, input logic nv);
		@(posedge core_clk);
		#1;
		rst_b    = 1'b0;
		prot     = p;
		addr4_nv = nv;
		repeat (4) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
	endtask

	// One read of NB bytes from BASE, judged on data, count, start clock and lines
	task automatic do_read(input logic [7:0] op, input int al, input int dl, input bit dtr, input bit plain,
		input int ab, input bit ok);
		int          ol;
		int          got;
		int          n;
		logic [31:0] a;
		ol  = (prot == 2'h2) ? 4 : (prot == 2'h1) ? 2 : 1;
		got = 0;
		a   = (ab == 24) ? {8'h00, BASE[23:0]} : BASE;
		for (n = 0; busy !== 1'b0; n++) begin
			if (n == 200) timeout();
			@(negedge core_clk);
		end
		@(posedge core_clk);
		#1;
		opcode = op;
		addr4  = (ab == 32);
		start  = 1'b1;
		oe_at  = -1;
		@(posedge core_clk);
		#1;
		start = 1'b0;
		for (n = 0; done !== 1'b1; n++) begin
			if (n == 4000) timeout();
			@(negedge core_clk);
			if (rd_valid === 1'b1) begin
				check(32'(rd_data), 32'(mem(a + 32'(got))), "data byte");
				got++;
			end
		end
		check(32'(got), ok ? 32'(NB) : 32'h0, "byte count");
		check(32'(oe_at), ok ? 32'(8 / ol + ab / (al * (dtr ? 2 : 1)) + (plain ? 0 : 8)) : 32'hffffffff, "start");
		if (ok) check(32'(oe_seen), (dl == 4) ? 32'hf : (dl == 2) ? 32'h3 : 32'h2, "data lines");
	endtask

	// ==========================================
	// Scenarios
	// ==========================================
	// Every read kind in the extended protocol, both address widths, double-edge for all kinds but plain read
	task automatic sc_extended();
		reset_to(2'h0, 1'b0);
		for (int k = 0; k < 6; k++) begin
			do_read(op4[k], al_t[k], dl_t[k], 1'b0, k == 0, 32, 1'b1);
			do_read(op3[k], al_t[k], dl_t[k], 1'b0, k == 0, 24, 1'b1);
			if (k > 0) do_read(opd[k], al_t[k], dl_t[k], 1'b1, 1'b0, 24, 1'b1);
		end
	endtask

	// Dual or quad protocol: supported kinds stream, the rest are ignored
	task automatic sc_narrow(input logic [1:0] p, input logic [5:0] okm);
		int w;
		w = (p == 2'h2) ? 4 : 2;
		reset_to(p, 1'b0);
		for (int k = 0; k < 6; k++) begin
			do_read(op3[k], w, w, 1'b0, k == 0, 24, okm[k]);
			if (k > 0) do_read(opd[k], w, w, 1'b1, 1'b0, 24, okm[k]);
		end
	endtask

	// Address width from the strap, then switched by exit and enter
	task automatic sc_mode();
		reset_to(2'h0, 1'b1);
		do_read(op3[1], 1, 1, 1'b0, 1'b0, 32, 1'b1);
		do_read(8'he9, 1, 1, 1'b0, 1'b0, 24, 1'b0);
		do_read(op3[1], 1, 1, 1'b0, 1'b0, 24, 1'b1);
		do_read(8'hb7, 1, 1, 1'b0, 1'b0, 32, 1'b0);
		do_read(opd[5], 4, 4, 1'b1, 1'b0, 32, 1'b1);
	endtask

	// ==========================================
	// Main sequence
	// ==========================================
	initial begin
		sc_extended();
		sc_narrow(2'h1, 6'b001110);
		sc_narrow(2'h2, 6'b110010);
		sc_mode();
		finish_test();
	end
endmodule // testbench
